// file: i2cs_bus_model.sv
// Behavioural far-side bus master for the status sequencer bench.
// Assumes open-drain lines with pull-ups: a released line reads high.
module i2cs_bus_model (
    output logic scl,
    output logic sda,
    output logic [3:0] fall_cnt
);
    timeunit 1ns;
    timeprecision 100ps;

    // ----------------------------------------------------------------
    // Line state
    // ----------------------------------------------------------------
    // Idle bus: both lines released; the clock stands still between frames
    initial begin
        scl = 1'b1;
        sda = 1'b1;
        fall_cnt = 4'h0;
    end

    // ----------------------------------------------------------------
    // Frame pieces
    // ----------------------------------------------------------------
    // Start or restart; the 3 ns lead keeps line edges off core clock edges
    task automatic start;
        #3 sda = 1'b1;
        #40 scl = 1'b1;
        #40 sda = 1'b0;
        #40 scl = 1'b0;
    endtask

    // Stop: data rises while the clock is high
    task automatic stop;
        #40 sda = 1'b0;
        #40 scl = 1'b1;
        #40 sda = 1'b1;
        #40;
    endtask

    // Eight data bits MSB first, then the ack slot; a nack just releases data
    task automatic send_byte(input logic [7:0] b, input logic ack);
        for (int i = 0; i < 9; i++) begin
            sda = (i < 8) ? b[7-i] : ~ack;
            #40 scl = 1'b1;
            #80 scl = 1'b0;
            fall_cnt = 4'(i + 1);
            #40;
        end
    endtask
endmodule

// file: i2cs_pkg.sv
// Constants, field layouts and carrier types of the two-wire status sequencer.
// Assumes a single core clock; no other package is needed.
package i2cs_pkg;

    // ----------------------------------------------------------------
    // Register port map
    // ----------------------------------------------------------------
    localparam int unsigned REG_ADDR_W = 2;
    localparam logic [1:0] REG_CTRL = 2'h0;
    localparam logic [1:0] REG_OWN_ADDR = 2'h1;
    localparam logic [1:0] REG_STATUS = 2'h2;
    localparam logic [1:0] REG_DATA = 2'h3;
    localparam int unsigned CTRL_WTIM_BIT = 0;
    localparam int unsigned CTRL_SPIE_BIT = 1;
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] OWN_ADDR_RST = 8'h00;

    // ----------------------------------------------------------------
    // Bit timing within one byte on the wire
    // ----------------------------------------------------------------
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam logic [3:0] ACK_CLOCK = 4'h9;
    localparam logic [3:0] CNT_ONE = 4'h1;
    localparam logic [3:0] CNT_ZERO = 4'h0;
    // Extended codes start with the upper five bits 11110
    localparam logic [4:0] EXT_CODE_PREFIX = 5'h1E;

    // ----------------------------------------------------------------
    // Status carrier, bit 7 down to bit 0
    // ----------------------------------------------------------------
    typedef struct packed {
        logic msts;
        logic ald;
        logic exc;
        logic coi;
        logic trc;
        logic ackd;
        logic std;
        logic spd;
    } i2cs_status_type;

    localparam i2cs_status_type STATUS_RST = 8'h00;
    localparam i2cs_status_type STATUS_STOP = 8'h01;

    // Sampled line pair
    typedef struct packed {
        logic scl;
        logic sda;
    } i2cs_line_type;

    localparam i2cs_line_type LINE_IDLE = 2'h3;

    // Position within a transfer
    typedef enum logic [1:0] {
        PH_IDLE = 2'b00,
        PH_ADDR = 2'b01,
        PH_DATA = 2'b10
    } i2cs_phase_type;

endpackage

// file: i2cs_status_seq.sv
// Status capture and event sequencing of a two-wire serial bus unit.
// Assumes the line pins are asynchronous inputs and master_active comes
// from the bus controller on core_clk.
module i2cs_status_seq
    import i2cs_pkg::*;
(
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic scl_pin,
    input wire logic sda_pin,
    input wire logic master_active,
    input wire logic [REG_ADDR_W-1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    output logic bus_event_irq,
    output i2cs_status_type bus_status
);

    // ----------------------------------------------------------------
    // Reset release
    // ----------------------------------------------------------------
    logic rst_meta_q;
    logic rst_n_q;

    // Release is synchronous so all flops leave reset on the same edge
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            rst_meta_q <= 1'h0;
            rst_n_q <= 1'h0;
        end else begin
            rst_meta_q <= 1'h1;
            rst_n_q <= rst_meta_q;
        end
    end

    // ----------------------------------------------------------------
    // Line synchronisers and condition detection
    // ----------------------------------------------------------------
    i2cs_line_type line_meta_q;
    i2cs_line_type line_sync_q;
    i2cs_line_type line_prev_q;
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;

    // Two flops per pin plus a third holding the previous sample; edge and condition logic compare the second and third stages
    always_ff @(posedge core_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            line_meta_q <= LINE_IDLE;
            line_sync_q <= LINE_IDLE;
            line_prev_q <= LINE_IDLE;
        end else begin
            line_meta_q <= '{scl: scl_pin, sda: sda_pin};
            line_sync_q <= line_meta_q;
            line_prev_q <= line_sync_q;
        end
    end

    // Data edges count as conditions only while the clock stays high
    assign scl_rise = line_sync_q.scl & ~line_prev_q.scl;
    assign scl_fall = ~line_sync_q.scl & line_prev_q.scl;
    assign start_det = line_sync_q.scl & line_prev_q.scl
                       & line_prev_q.sda & ~line_sync_q.sda;
    assign stop_det = line_sync_q.scl & line_prev_q.scl
                      & ~line_prev_q.sda & line_sync_q.sda;

    // ----------------------------------------------------------------
    // Software registers
    // ----------------------------------------------------------------
    logic [7:0] ctrl_q;
    logic [7:0] own_address_reg_q;
    logic [7:0] shift_q;
    logic [7:0] byte_q;
    logic wait_timing_select;
    logic stop_irq_enable;
    i2cs_status_type bus_status_reg_q;

    assign wait_timing_select = ctrl_q[CTRL_WTIM_BIT];
    assign stop_irq_enable = ctrl_q[CTRL_SPIE_BIT];

    // Control and own-address writes
    always_ff @(posedge core_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            ctrl_q <= CTRL_RST;
            own_address_reg_q <= OWN_ADDR_RST;
        end else if (reg_wr) begin
            if (reg_addr == REG_CTRL) begin
                ctrl_q <= reg_wdata;
            end
            if (reg_addr == REG_OWN_ADDR) begin
                own_address_reg_q <= reg_wdata;
            end
        end
    end

    // Read data stand one cycle after the strobe and only then
    always_ff @(posedge core_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                REG_CTRL: reg_rdata <= ctrl_q;
                REG_OWN_ADDR: reg_rdata <= own_address_reg_q;
                REG_STATUS: reg_rdata <= bus_status_reg_q;
                REG_DATA: reg_rdata <= byte_q;
                default: reg_rdata <= 8'h00;
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    // ----------------------------------------------------------------
    // Bit counter, shift register and acknowledge sample
    // ----------------------------------------------------------------
    logic [3:0] bit_cnt_q;
    logic ack_q;
    logic eighth_fall;
    logic ninth_fall;

    assign eighth_fall = scl_fall & (bit_cnt_q == BYTE_BITS);
    assign ninth_fall = scl_fall & (bit_cnt_q == ACK_CLOCK);

    // A start or stop restarts the count; the ninth fall closes a byte
    always_ff @(posedge core_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            bit_cnt_q <= CNT_ZERO;
            shift_q <= 8'h00;
            ack_q <= 1'h0;
        end else if (start_det | stop_det) begin
            bit_cnt_q <= CNT_ZERO;
        end else if (scl_rise) begin
            bit_cnt_q <= bit_cnt_q + CNT_ONE;
            if (bit_cnt_q < BYTE_BITS) begin
                shift_q <= {shift_q[6:0], line_sync_q.sda};
            end else begin
                ack_q <= ~line_sync_q.sda;
            end
        end else if (ninth_fall) begin
            bit_cnt_q <= CNT_ZERO;
        end
    end

    // Whole byte copied at its eighth fall, so the clock pulse of a stop
    // or restart cannot push a stray bit into what software reads
    always_ff @(posedge core_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            byte_q <= 8'h00;
        end else if (eighth_fall) begin
            byte_q <= shift_q;
        end
    end

    // ----------------------------------------------------------------
    // Transfer phase
    // ----------------------------------------------------------------
    i2cs_phase_type phase_q;
    logic restart_q;
    logic first_data_q;
    logic participating;

    assign participating = bus_status_reg_q.msts | bus_status_reg_q.exc
                           | bus_status_reg_q.coi;

    // Address follows every start; data follows a closed address byte
    always_ff @(posedge core_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            phase_q <= PH_IDLE;
        end else if (stop_det) begin
            phase_q <= PH_IDLE;
        end else if (start_det) begin
            phase_q <= PH_ADDR;
        end else begin
            case (phase_q)
                PH_IDLE: phase_q <= PH_IDLE;
                PH_ADDR: if (ninth_fall) begin
                    phase_q <= PH_DATA;
                end
                PH_DATA: phase_q <= PH_DATA;
                default: phase_q <= PH_IDLE;
            endcase
        end
    end

    // A start seen while holding a role marks the next address a restart
    always_ff @(posedge core_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            restart_q <= 1'h0;
        end else if (stop_det) begin
            restart_q <= 1'h0;
        end else if (start_det) begin
            restart_q <= participating;
        end
    end

    // ----------------------------------------------------------------
    // Address decode and interrupt points
    // ----------------------------------------------------------------
    logic own_match;
    logic ext_hit;
    logic addr_fire;
    logic data_fire;
    logic keep_std;

    assign own_match = shift_q[7:1] == own_address_reg_q[7:1];
    assign ext_hit = shift_q[7:3] == EXT_CODE_PREFIX;

    // Slave reacts to its own address, a code or a restart; master always
    assign addr_fire = (phase_q == PH_ADDR) & ninth_fall
                       & (master_active | own_match | ext_hit | restart_q);
    // Data point follows the timing select
    assign data_fire = (phase_q == PH_DATA) & participating
                       & (wait_timing_select ? ninth_fall : eighth_fall);
    // A received code keeps start in its first ninth-clock data status
    assign keep_std = bus_status_reg_q.exc & ~bus_status_reg_q.msts
                      & wait_timing_select & first_data_q;

    // First data byte after each reported address
    always_ff @(posedge core_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            first_data_q <= 1'h0;
        end else if (addr_fire) begin
            first_data_q <= 1'h1;
        end else if (data_fire | stop_det) begin
            first_data_q <= 1'h0;
        end
    end

    // ----------------------------------------------------------------
    // Status register
    // ----------------------------------------------------------------
    // Arbitration handling lives elsewhere, so bit 6 stays clear here
    always_ff @(posedge core_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            bus_status_reg_q <= STATUS_RST;
        end else if (stop_det) begin
            bus_status_reg_q <= STATUS_STOP;
        end else if (start_det) begin
            bus_status_reg_q.std <= 1'h1;
            bus_status_reg_q.spd <= 1'h0;
        end else if (addr_fire) begin
            // Roles are rebuilt on every reported address, so restarts switch form
            bus_status_reg_q.msts <= master_active;
            bus_status_reg_q.ald <= 1'h0;
            bus_status_reg_q.exc <= ext_hit;
            bus_status_reg_q.coi <= ~master_active & own_match & ~ext_hit;
            // A master writes when the direction bit is low
            bus_status_reg_q.trc <= master_active ^ shift_q[0];
            bus_status_reg_q.ackd <= ack_q;
            bus_status_reg_q.std <= 1'h1;
            bus_status_reg_q.spd <= 1'h0;
        end else if (data_fire) begin
            // No acknowledge has been seen yet at the eighth fall
            bus_status_reg_q.ackd <= wait_timing_select & ack_q;
            bus_status_reg_q.std <= keep_std;
        end
    end

    assign bus_status = bus_status_reg_q;

    // ----------------------------------------------------------------
    // Event output
    // ----------------------------------------------------------------
    logic irq_q;

    // One-cycle pulse, raised with the status it announces
    always_ff @(posedge core_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            irq_q <= 1'h0;
        end else begin
            irq_q <= addr_fire | data_fire | (stop_det & stop_irq_enable);
        end
    end

    assign bus_event_irq = irq_q;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    // Clock rises in the current byte, back to one after the ninth, counted apart from the bit counter
    logic [3:0] rise_seen_q;

    always_ff @(posedge core_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            rise_seen_q <= CNT_ZERO;
        end else if (start_det | stop_det) begin
            rise_seen_q <= CNT_ZERO;
        end else if (scl_rise) begin
            rise_seen_q <= (rise_seen_q == ACK_CLOCK) ? CNT_ONE : rise_seen_q + CNT_ONE;
        end
    end

    default clocking dclk @(posedge core_clk);
    endclocking
    default disable iff (!rst_n_q);

    a_stop_status: assert property (stop_det |=> bus_status_reg_q == STATUS_STOP)
        else $error("stop did not leave only the stop bit");

    a_stop_gate: assert property (stop_det |=> bus_event_irq == $past(stop_irq_enable))
        else $error("stop event not gated by its enable");

    a_always_fire: assert property ((addr_fire | data_fire) && !stop_irq_enable |=> bus_event_irq)
        else $error("event point lost while stop enable clear");

    a_master_addr: assert property (addr_fire && master_active && ack_q
        |=> bus_event_irq && bus_status_reg_q.msts && bus_status_reg_q.ackd && bus_status_reg_q.std)
        else $error("master address status wrong");

    a_ext_master: assert property (addr_fire && master_active && ext_hit
        |=> bus_status_reg_q.msts && bus_status_reg_q.exc && bus_status_reg_q.std)
        else $error("master code status wrong");

    a_slave_match: assert property (addr_fire && !master_active && own_match && !ext_hit
        |=> bus_status_reg_q[7:4] == 4'h1 && bus_status_reg_q.std)
        else $error("slave match status wrong");

    a_slave_code: assert property (addr_fire && !master_active && ext_hit
        |=> bus_status_reg_q[7:4] == 4'h2 && bus_status_reg_q.std)
        else $error("slave code status wrong");

    a_foreign_restart: assert property (addr_fire && !master_active && !own_match && !ext_hit
        |=> bus_event_irq && bus_status_reg_q[7:4] == 4'h0 && bus_status_reg_q.std)
        else $error("restart to foreign address status wrong");

    a_foreign_silent: assert property ((phase_q == PH_ADDR) && ninth_fall && !master_active && !own_match
        && !ext_hit && !restart_q |=> !bus_event_irq)
        else $error("unaddressed slave raised an event");

    a_data_eighth: assert property (data_fire && !wait_timing_select
        |=> bus_event_irq && !bus_status_reg_q.ackd && !bus_status_reg_q.std)
        else $error("eighth clock data status wrong");

    a_data_ninth: assert property (data_fire && wait_timing_select && !keep_std
        |=> bus_status_reg_q.ackd == $past(ack_q) && !bus_status_reg_q.std)
        else $error("ninth clock data status wrong");

    a_data_timing: assert property (data_fire |-> (wait_timing_select ? rise_seen_q == ACK_CLOCK
        : rise_seen_q == BYTE_BITS))
        else $error("data event at wrong clock");

    a_start_flag: assert property (start_det && !stop_det |=> bus_status_reg_q.std
        && !bus_status_reg_q.spd)
        else $error("start did not set its bit");

endmodule

// file: i2cs_status_seq_bench.sv
// Self-checking bench of the status sequencer, as master and as slave.
// Assumes the package and the bus model are compiled before this file.
module i2cs_status_seq_bench import i2cs_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;

    // ----------------------------------------------------------------
    // Signals and instances
    // ----------------------------------------------------------------
    logic core_clk = 1'b0;
    logic nrst = 1'b0;
    logic scl_line;
    logic sda_line;
    logic [3:0] fall_cnt;
    logic master_active = 1'b0;
    logic [REG_ADDR_W-1:0] reg_addr = 2'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic bus_event_irq;
    i2cs_status_type bus_status;
    int n_errors = 0;
    int checks = 0;
    logic [11:0] got_q[$];

    always #10 core_clk = ~core_clk;

    i2cs_bus_model u_bus (.scl(scl_line), .sda(sda_line), .fall_cnt(fall_cnt));

    i2cs_status_seq u_dut (
        .core_clk(core_clk), .nrst(nrst), .scl_pin(scl_line), .sda_pin(sda_line),
        .master_active(master_active), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .bus_event_irq(bus_event_irq), .bus_status(bus_status)
    );

    // Log each interrupt with the clock fall it followed; falling edge avoids races
    always @(negedge core_clk) begin
        if (bus_event_irq === 1'b1)
            got_q.push_back({fall_cnt, bus_status});
    end

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic summarize;
        $display("checks %0d, mismatches %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic compare(input logic [11:0] got, input logic [11:0] exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask

    // Next logged event against fall count and status; a missing event reads 000
    task automatic exp_ev(input logic [3:0] f, input logic [7:0] s);
        if (got_q.size() == 0)
            compare(12'h000, {f, s});
        else
            compare(got_q.pop_front(), {f, s});
    endtask

    // No event beyond those already expected
    task automatic exp_none;
        compare(12'(got_q.size()), 12'h000);
        got_q.delete();
    endtask

    task automatic reg_write(input logic [1:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic reg_check(input logic [1:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        compare({4'h0, reg_rdata}, {4'h0, d});
    endtask

    task automatic setup(input logic ma, input logic w, input logic sp);
        logic [7:0] c;
        c = 8'h00;
        c[CTRL_WTIM_BIT] = w;
        c[CTRL_SPIE_BIT] = sp;
        reg_write(REG_CTRL, c);
        master_active <= ma;
    endtask

    // Stop detection plus output latency is a few cycles; six is ample
    task automatic settle;
        repeat (6) @(posedge core_clk);
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_regs;
        reg_check(REG_CTRL, CTRL_RST);
        reg_check(REG_OWN_ADDR, OWN_ADDR_RST);
        reg_check(REG_STATUS, STATUS_RST);
        reg_write(REG_STATUS, 8'hFF);
        reg_check(REG_STATUS, STATUS_RST);
        reg_write(REG_OWN_ADDR, 8'hA4);
        reg_check(REG_OWN_ADDR, 8'hA4);
        $display("test regs done");
    endtask

    task automatic t_master_tx;
        setup(1'b1, 1'b0, 1'b1);
        u_bus.start();
        u_bus.send_byte(8'hA0, 1'b1);
        u_bus.send_byte(8'h3C, 1'b1);
        u_bus.send_byte(8'hC3, 1'b1);
        u_bus.stop();
        settle();
        exp_ev(4'h9, 8'h8E);
        exp_ev(4'h8, 8'h88);
        exp_ev(4'h8, 8'h88);
        exp_ev(4'h9, 8'h01);
        exp_none();
        reg_check(REG_DATA, 8'hC3);
        $display("test master write done");
    endtask

    // Restart with stop interrupt disabled: the stop must stay silent
    task automatic t_master_rs;
        setup(1'b1, 1'b1, 1'b0);
        u_bus.start();
        u_bus.send_byte(8'hA1, 1'b1);
        u_bus.send_byte(8'h5A, 1'b1);
        u_bus.start();
        u_bus.send_byte(8'hA0, 1'b1);
        u_bus.send_byte(8'h5A, 1'b0);
        u_bus.stop();
        settle();
        exp_ev(4'h9, 8'h86);
        exp_ev(4'h9, 8'h84);
        exp_ev(4'h9, 8'h8E);
        exp_ev(4'h9, 8'h88);
        exp_none();
        reg_check(REG_STATUS, STATUS_STOP);
        $display("test master restart done");
    endtask

    task automatic t_master_ext(input logic w);
        setup(1'b1, w, 1'b1);
        u_bus.start();
        u_bus.send_byte(8'hF0, 1'b1);
        u_bus.send_byte(8'h33, 1'b1);
        u_bus.stop();
        settle();
        exp_ev(4'h9, 8'hAE);
        exp_ev(w ? 4'h9 : 4'h8, w ? 8'hAC : 8'hA8);
        exp_ev(4'h9, 8'h01);
        exp_none();
        $display("test master extended done");
    endtask

    // Foreign frame first, then own address, restart to a foreign address
    task automatic t_slave(input logic w);
        setup(1'b0, w, 1'b1);
        u_bus.start();
        u_bus.send_byte(8'h60, 1'b0);
        u_bus.send_byte(8'h11, 1'b1);
        u_bus.stop();
        settle();
        exp_ev(4'h9, 8'h01);
        exp_none();
        u_bus.start();
        u_bus.send_byte(8'hA5, 1'b1);
        u_bus.send_byte(8'h22, 1'b1);
        u_bus.send_byte(8'h23, 1'b0);
        u_bus.start();
        u_bus.send_byte(8'h60, 1'b0);
        u_bus.send_byte(8'h24, 1'b1);
        u_bus.stop();
        settle();
        exp_ev(4'h9, 8'h1E);
        exp_ev(w ? 4'h9 : 4'h8, w ? 8'h1C : 8'h18);
        exp_ev(w ? 4'h9 : 4'h8, 8'h18);
        exp_ev(4'h9, 8'h02);
        exp_ev(4'h9, 8'h01);
        exp_none();
        $display("test slave done");
    endtask

    task automatic t_slave_code(input logic w);
        setup(1'b0, w, 1'b1);
        u_bus.start();
        u_bus.send_byte(8'hF0, 1'b0);
        u_bus.send_byte(8'h44, 1'b1);
        u_bus.send_byte(8'h45, 1'b1);
        u_bus.start();
        u_bus.send_byte(8'hA4, 1'b1);
        u_bus.send_byte(8'h46, 1'b1);
        u_bus.start();
        u_bus.send_byte(8'hF0, 1'b0);
        u_bus.send_byte(8'h47, 1'b1);
        u_bus.stop();
        settle();
        exp_ev(4'h9, 8'h22);
        exp_ev(w ? 4'h9 : 4'h8, w ? 8'h26 : 8'h20);
        exp_ev(w ? 4'h9 : 4'h8, w ? 8'h24 : 8'h20);
        exp_ev(4'h9, 8'h16);
        exp_ev(w ? 4'h9 : 4'h8, w ? 8'h14 : 8'h10);
        exp_ev(4'h9, 8'h22);
        exp_ev(w ? 4'h9 : 4'h8, w ? 8'h26 : 8'h20);
        exp_ev(4'h9, 8'h01);
        exp_none();
        $display("test slave code done");
    endtask

    // ----------------------------------------------------------------
    // Main sequence and hang guard
    // ----------------------------------------------------------------
    initial begin
        repeat (10) @(posedge core_clk);
        nrst <= 1'b1;
        repeat (4) @(posedge core_clk);
        t_regs();
        t_master_tx();
        t_master_rs();
        t_master_ext(1'b0);
        t_master_ext(1'b1);
        t_slave(1'b0);
        t_slave(1'b1);
        t_slave_code(1'b0);
        t_slave_code(1'b1);
        summarize();
    end

    initial begin
        repeat (100000) @(posedge core_clk);
        n_errors++;
        summarize();
    end
endmodule
